// [atc_pkg.sv]
package atc_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ATC_ADDR_W = 8;
    localparam int ATC_DATA_W = 32;
    localparam int ATC_CNT_W = 16;
    localparam int ATC_SEL_W = 4;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [ATC_ADDR_W-1:0] ATC_OFS_CTRL = 8'h00;
    localparam logic [ATC_ADDR_W-1:0] ATC_OFS_SRC = 8'h04;
    localparam logic [ATC_ADDR_W-1:0] ATC_OFS_BUF_SIZE = 8'h08;
    localparam logic [ATC_ADDR_W-1:0] ATC_OFS_PRETRIG = 8'h0C;
    localparam logic [ATC_ADDR_W-1:0] ATC_OFS_DIV = 8'h10;
    localparam logic [ATC_ADDR_W-1:0] ATC_OFS_DELAY = 8'h14;
    localparam logic [ATC_ADDR_W-1:0] ATC_OFS_CMD = 8'h18;
    localparam logic [ATC_ADDR_W-1:0] ATC_OFS_STATUS = 8'h1C;
    localparam logic [ATC_ADDR_W-1:0] ATC_OFS_COUNT = 8'h20;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int ATC_CTRL_CONT = 0;
    localparam int ATC_CTRL_START_EN = 1;
    localparam int ATC_CTRL_START_FALL = 2;
    localparam int ATC_CTRL_REF_EN = 3;
    localparam int ATC_CTRL_REF_FALL = 4;
    localparam int ATC_CTRL_HOLD_EN = 5;
    localparam int ATC_CTRL_HOLD_LOW = 6;
    localparam int ATC_CTRL_START_ROUTE = 7;
    localparam int ATC_CTRL_REF_ROUTE = 8;
    localparam int ATC_SRC_START = 0;
    localparam int ATC_SRC_REF = 4;
    localparam int ATC_SRC_HOLD = 8;
    localparam int ATC_SRC_START_LINE = 12;
    localparam int ATC_SRC_REF_LINE = 16;
    localparam int ATC_CMD_START = 0;
    localparam int ATC_CMD_STOP = 1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [ATC_CNT_W-1:0] ATC_RST_BUF_SIZE = 16'h0010;
    localparam logic [ATC_CNT_W-1:0] ATC_RST_DIV = 16'h0004;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT_START,
        ST_DELAY,
        ST_ACQ,
        ST_POST
    } atc_state_t;

    typedef struct packed {
        logic cont;
        logic start_en;
        logic start_fall;
        logic ref_en;
        logic ref_fall;
        logic hold_en;
        logic hold_low;
        logic start_route;
        logic ref_route;
        logic [ATC_SEL_W-1:0] start_sel;
        logic [ATC_SEL_W-1:0] ref_sel;
        logic [ATC_SEL_W-1:0] hold_sel;
        logic [ATC_SEL_W-1:0] start_line;
        logic [ATC_SEL_W-1:0] ref_line;
        logic [ATC_CNT_W-1:0] buf_size;
        logic [ATC_CNT_W-1:0] pretrig;
        logic [ATC_CNT_W-1:0] div;
        logic [ATC_CNT_W-1:0] delay;
    } atc_cfg_t;

    typedef struct packed {
        logic sample;
        logic [ATC_CNT_W-1:0] addr;
        logic active;
        logic done;
    } atc_acq_out_t;

endpackage : atc_pkg

// [atc_sync_edge.sv]
`timescale 1ns/1ps

module atc_sync_edge #(
    parameter int WIDTH = 16
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Raw sources and conditioned results.
    input wire logic [WIDTH-1:0] raw_i,
    output logic [WIDTH-1:0] level_o,
    output logic [WIDTH-1:0] rise_o,
    output logic [WIDTH-1:0] fall_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] lvl;
        logic [WIDTH-1:0] prev;
    } atc_sync_state_t;

    atc_sync_state_t s_reg;
    atc_sync_state_t s_next;

    // ------------------------------------------------------------------
    // Two-flop synchroniser and edge compare of consecutive samples.
    // ------------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.meta = raw_i;
        s_next.lvl = s_reg.meta;
        s_next.prev = s_reg.lvl;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign level_o = s_reg.lvl;
    assign rise_o = s_reg.lvl & ~s_reg.prev;
    assign fall_o = ~s_reg.lvl & s_reg.prev;

endmodule : atc_sync_edge

// [atc_trigger_ctrl.sv]
// What this block does
// - Digital start source begins acquisition on its selected rising or falling edge.
// - Without a trigger, a software start command begins acquisition.
// - Finite mode without reference stops after the configured sample count.
// - Continuous mode without reference runs until a software stop command.
// - Start-triggered acquisition takes no samples before the start event.
// - Programmable delay between start event and first internal sample.
// - Start source selectable from function lines, counter outputs or internal signals.
// - Analog start begins on first selected edge of the threshold event.
// - Start event drives a routed function line as an active-high pulse.
// - Posttrigger count equals buffer size minus pretrigger count.
// - Buffer fills from start; reference detection arms after pretrigger samples.
// - Reference conditions before the pretrigger count is reached are ignored.
// - Full buffer before reference overwrites oldest sample, circularly.
// - After reference, keep storing until posttrigger count, then end.
// - Digital reference detected on the selected rising or falling edge.
// - Analog reference is the first selected edge of the threshold event.
// - Reference event may be routed to any output function line.
// - Active hold level suspends the internal sample clock; inactive resumes it.
// - Hold input has programmable active polarity, high or low.
// - Hold input is evaluated by level only, never by edge.
// - Analog hold suspends at one threshold level and resumes at the other.
// - Start, reference and hold sources are selected independently.
`timescale 1ns/1ps

module atc_trigger_ctrl #(
    parameter int NUM_LINES = 8,
    parameter int NUM_CNT = 2,
    parameter int NUM_INT = 4,
    parameter int NUM_ANA = 2
) (
    // Clock and reset.
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    // Register port.
    input wire logic [atc_pkg::ATC_ADDR_W-1:0] ADDR_I,
    input wire logic [atc_pkg::ATC_DATA_W-1:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [atc_pkg::ATC_DATA_W-1:0] RDATA_O,
    // Trigger sources.
    input wire logic [NUM_LINES-1:0] FUNC_LINE_I,
    input wire logic [NUM_CNT-1:0] CNT_OUT_I,
    input wire logic [NUM_INT-1:0] INT_SIG_I,
    input wire logic [NUM_ANA-1:0] ANA_EVT_I,
    // Acquisition outputs.
    output logic SAMPLE_O,
    output logic [atc_pkg::ATC_CNT_W-1:0] BUF_ADDR_O,
    output logic ACTIVE_O,
    output logic DONE_O,
    output logic [NUM_LINES-1:0] FUNC_LINE_O
);

    localparam int NSRC = NUM_LINES + NUM_CNT + NUM_INT + NUM_ANA;
    localparam int CW = atc_pkg::ATC_CNT_W;
    localparam int SW = atc_pkg::ATC_SEL_W;

    typedef struct packed {
        atc_pkg::atc_state_t st;
        atc_pkg::atc_cfg_t cfg;
        logic [CW-1:0] dly_cnt;
        logic [CW-1:0] div_cnt;
        logic [CW-1:0] cnt;
        logic [CW-1:0] pre_cnt;
        logic [CW-1:0] post_cnt;
        logic [atc_pkg::ATC_DATA_W-1:0] rdata;
        logic start_pulse;
        logic ref_pulse;
        logic [NUM_LINES-1:0] line_out;
        atc_pkg::atc_acq_out_t acq;
    } atc_core_state_t;

    atc_core_state_t s_reg;
    atc_core_state_t s_next;

    logic [NSRC-1:0] src_raw;
    logic [NSRC-1:0] src_lvl;
    logic [NSRC-1:0] src_rise;
    logic [NSRC-1:0] src_fall;
    logic start_evt;
    logic ref_evt;
    logic held;
    logic armed;
    logic tick;
    logic [CW-1:0] post_total;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic pick(input logic [NSRC-1:0] v, input logic [SW-1:0] idx);
        pick = (32'(idx) < NSRC) ? v[idx] : 1'b0;
    endfunction : pick

    function automatic logic [CW-1:0] wrap_inc(input logic [CW-1:0] a, input logic [CW-1:0] size);
        logic [CW-1:0] nx;
        nx = a + 16'h0001;
        wrap_inc = (nx >= size) ? '0 : nx;
    endfunction : wrap_inc

    // ------------------------------------------------------------------
    // Source conditioning
    // ------------------------------------------------------------------
    assign src_raw = {ANA_EVT_I, INT_SIG_I, CNT_OUT_I, FUNC_LINE_I};

    atc_sync_edge #(
        .WIDTH(NSRC)
    ) u_sync (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .raw_i(src_raw),
        .level_o(src_lvl),
        .rise_o(src_rise),
        .fall_o(src_fall)
    );

    // Each trigger has its own selector, so all three may differ.
    assign start_evt = s_reg.cfg.start_fall ? pick(src_fall, s_reg.cfg.start_sel)
                                            : pick(src_rise, s_reg.cfg.start_sel);
    assign ref_evt = s_reg.cfg.ref_fall ? pick(src_fall, s_reg.cfg.ref_sel)
                                        : pick(src_rise, s_reg.cfg.ref_sel);
    // The hold is a pure level; polarity picks which level suspends.
    assign held = s_reg.cfg.hold_en
        & (pick(src_lvl, s_reg.cfg.hold_sel) ^ s_reg.cfg.hold_low);
    assign armed = (s_reg.pre_cnt == s_reg.cfg.pretrig);
    assign post_total = (s_reg.cfg.pretrig > s_reg.cfg.buf_size) ? '0
                        : s_reg.cfg.buf_size - s_reg.cfg.pretrig;
    // The sample divider fires on zero and freezes while held.
    assign tick = ~held && (s_reg.div_cnt == '0);

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.rdata = '0;
        s_next.start_pulse = 1'b0;
        s_next.ref_pulse = 1'b0;
        s_next.acq.sample = 1'b0;

        if (WR_I) begin
            unique case (ADDR_I)
                atc_pkg::ATC_OFS_CTRL: begin
                    s_next.cfg.cont = WDATA_I[atc_pkg::ATC_CTRL_CONT];
                    s_next.cfg.start_en = WDATA_I[atc_pkg::ATC_CTRL_START_EN];
                    s_next.cfg.start_fall = WDATA_I[atc_pkg::ATC_CTRL_START_FALL];
                    s_next.cfg.ref_en = WDATA_I[atc_pkg::ATC_CTRL_REF_EN];
                    s_next.cfg.ref_fall = WDATA_I[atc_pkg::ATC_CTRL_REF_FALL];
                    s_next.cfg.hold_en = WDATA_I[atc_pkg::ATC_CTRL_HOLD_EN];
                    s_next.cfg.hold_low = WDATA_I[atc_pkg::ATC_CTRL_HOLD_LOW];
                    s_next.cfg.start_route = WDATA_I[atc_pkg::ATC_CTRL_START_ROUTE];
                    s_next.cfg.ref_route = WDATA_I[atc_pkg::ATC_CTRL_REF_ROUTE];
                end
                atc_pkg::ATC_OFS_SRC: begin
                    s_next.cfg.start_sel = WDATA_I[atc_pkg::ATC_SRC_START +: SW];
                    s_next.cfg.ref_sel = WDATA_I[atc_pkg::ATC_SRC_REF +: SW];
                    s_next.cfg.hold_sel = WDATA_I[atc_pkg::ATC_SRC_HOLD +: SW];
                    s_next.cfg.start_line = WDATA_I[atc_pkg::ATC_SRC_START_LINE +: SW];
                    s_next.cfg.ref_line = WDATA_I[atc_pkg::ATC_SRC_REF_LINE +: SW];
                end
                atc_pkg::ATC_OFS_BUF_SIZE: s_next.cfg.buf_size = WDATA_I[CW-1:0];
                atc_pkg::ATC_OFS_PRETRIG: s_next.cfg.pretrig = WDATA_I[CW-1:0];
                atc_pkg::ATC_OFS_DIV: s_next.cfg.div = WDATA_I[CW-1:0];
                atc_pkg::ATC_OFS_DELAY: s_next.cfg.delay = WDATA_I[CW-1:0];
                default: begin
                end
            endcase
        end

        if (RD_I) begin
            unique case (ADDR_I)
                atc_pkg::ATC_OFS_CTRL: s_next.rdata = 32'({s_reg.cfg.ref_route, s_reg.cfg.start_route,
                    s_reg.cfg.hold_low, s_reg.cfg.hold_en, s_reg.cfg.ref_fall, s_reg.cfg.ref_en,
                    s_reg.cfg.start_fall, s_reg.cfg.start_en, s_reg.cfg.cont});
                atc_pkg::ATC_OFS_SRC: s_next.rdata = 32'({s_reg.cfg.ref_line, s_reg.cfg.start_line,
                    s_reg.cfg.hold_sel, s_reg.cfg.ref_sel, s_reg.cfg.start_sel});
                atc_pkg::ATC_OFS_BUF_SIZE: s_next.rdata = 32'(s_reg.cfg.buf_size);
                atc_pkg::ATC_OFS_PRETRIG: s_next.rdata = 32'(s_reg.cfg.pretrig);
                atc_pkg::ATC_OFS_DIV: s_next.rdata = 32'(s_reg.cfg.div);
                atc_pkg::ATC_OFS_DELAY: s_next.rdata = 32'(s_reg.cfg.delay);
                atc_pkg::ATC_OFS_STATUS: s_next.rdata = 32'({held,
                    armed && (s_reg.st == atc_pkg::ST_ACQ), s_reg.acq.done, s_reg.acq.active});
                atc_pkg::ATC_OFS_COUNT: s_next.rdata = 32'(s_reg.cnt);
                default: s_next.rdata = '0;
            endcase
        end

        unique case (s_reg.st)
            atc_pkg::ST_IDLE: begin
                if (WR_I && ADDR_I == atc_pkg::ATC_OFS_CMD && WDATA_I[atc_pkg::ATC_CMD_START]) begin
                    s_next.acq.done = 1'b0;
                    s_next.cnt = '0;
                    s_next.pre_cnt = '0;
                    s_next.post_cnt = '0;
                    s_next.dly_cnt = '0;
                    s_next.acq.addr = '0;
                    s_next.acq.active = 1'b1;
                    // With a trigger the command only arms the wait.
                    s_next.st = s_reg.cfg.start_en ? atc_pkg::ST_WAIT_START : atc_pkg::ST_DELAY;
                end
            end
            atc_pkg::ST_WAIT_START: begin
                if (start_evt) begin
                    s_next.start_pulse = 1'b1;
                    s_next.st = atc_pkg::ST_DELAY;
                end
            end
            atc_pkg::ST_DELAY: begin
                if (s_reg.dly_cnt >= s_reg.cfg.delay) begin
                    s_next.div_cnt = '0;
                    s_next.st = atc_pkg::ST_ACQ;
                end else begin
                    s_next.dly_cnt = s_reg.dly_cnt + 16'h0001;
                end
            end
            atc_pkg::ST_ACQ: begin
                if (s_reg.cfg.ref_en && armed && ref_evt) begin
                    s_next.ref_pulse = 1'b1;
                    s_next.post_cnt = '0;
                    s_next.st = atc_pkg::ST_POST;
                end else if (tick) begin
                    s_next.acq.sample = 1'b1;
                    s_next.cnt = s_reg.cnt + 16'h0001;
                    if (s_reg.cfg.ref_en) begin
                        s_next.acq.addr = wrap_inc(s_reg.acq.addr, s_reg.cfg.buf_size);
                        if (!armed) begin
                            s_next.pre_cnt = s_reg.pre_cnt + 16'h0001;
                        end
                    end else if (s_reg.cfg.cont) begin
                        s_next.acq.addr = wrap_inc(s_reg.acq.addr, s_reg.cfg.buf_size);
                    end else begin
                        s_next.acq.addr = s_reg.acq.addr + 16'h0001;
                        if (s_reg.cnt + 16'h0001 >= s_reg.cfg.buf_size) begin
                            s_next.acq.active = 1'b0;
                            s_next.acq.done = 1'b1;
                            s_next.st = atc_pkg::ST_IDLE;
                        end
                    end
                end
            end
            atc_pkg::ST_POST: begin
                if (s_reg.post_cnt >= post_total) begin
                    s_next.acq.active = 1'b0;
                    s_next.acq.done = 1'b1;
                    s_next.st = atc_pkg::ST_IDLE;
                end else if (tick) begin
                    s_next.acq.sample = 1'b1;
                    s_next.cnt = s_reg.cnt + 16'h0001;
                    s_next.post_cnt = s_reg.post_cnt + 16'h0001;
                    s_next.acq.addr = wrap_inc(s_reg.acq.addr, s_reg.cfg.buf_size);
                end
            end
        endcase

        // The divider reloads on each tick and only runs while sampling.
        if ((s_reg.st == atc_pkg::ST_ACQ || s_reg.st == atc_pkg::ST_POST) && !held) begin
            s_next.div_cnt = (s_reg.div_cnt == '0) ? s_reg.cfg.div - 16'h0001
                                                  : s_reg.div_cnt - 16'h0001;
        end

        // A stop command ends any running acquisition.
        if (s_reg.st != atc_pkg::ST_IDLE && WR_I && ADDR_I == atc_pkg::ATC_OFS_CMD
            && WDATA_I[atc_pkg::ATC_CMD_STOP]) begin
            s_next.acq.sample = 1'b0;
            s_next.acq.active = 1'b0;
            s_next.acq.done = 1'b1;
            s_next.st = atc_pkg::ST_IDLE;
        end

        for (int i = 0; i < NUM_LINES; i++) begin
            s_next.line_out[i] = (s_next.start_pulse && s_reg.cfg.start_route
                                  && 32'(s_reg.cfg.start_line) == i)
                               || (s_next.ref_pulse && s_reg.cfg.ref_route
                                  && 32'(s_reg.cfg.ref_line) == i);
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            s_reg <= '0;
            s_reg.st <= atc_pkg::ST_IDLE;
            s_reg.cfg.buf_size <= atc_pkg::ATC_RST_BUF_SIZE;
            s_reg.cfg.div <= atc_pkg::ATC_RST_DIV;
        end else begin
            s_reg <= s_next;
        end
    end

    assign RDATA_O = s_reg.rdata;
    assign SAMPLE_O = s_reg.acq.sample;
    assign BUF_ADDR_O = s_reg.acq.addr;
    assign ACTIVE_O = s_reg.acq.active;
    assign DONE_O = s_reg.acq.done;
    assign FUNC_LINE_O = s_reg.line_out;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (RST_I);

    AST_START_FROM_WAIT: assert property (
        s_reg.start_pulse |-> $past(s_reg.st) == atc_pkg::ST_WAIT_START && $past(start_evt))
        else $error("start pulse without a start edge while waiting");

    AST_SW_START: assert property (
        s_reg.st == atc_pkg::ST_IDLE && !s_reg.cfg.start_en && WR_I && ADDR_I == atc_pkg::ATC_OFS_CMD
        && WDATA_I[atc_pkg::ATC_CMD_START] && !WDATA_I[atc_pkg::ATC_CMD_STOP]
        |=> s_reg.st == atc_pkg::ST_DELAY && s_reg.acq.active)
        else $error("software start did not begin acquisition");

    AST_FINITE_BOUND: assert property (
        s_reg.acq.active && !s_reg.cfg.ref_en && !s_reg.cfg.cont && s_reg.cfg.buf_size != '0
        |-> s_reg.cnt < s_reg.cfg.buf_size)
        else $error("finite acquisition exceeded its sample count");

    AST_SW_STOP: assert property (
        s_reg.st != atc_pkg::ST_IDLE && WR_I && ADDR_I == atc_pkg::ATC_OFS_CMD
        && WDATA_I[atc_pkg::ATC_CMD_STOP] |=> s_reg.st == atc_pkg::ST_IDLE && s_reg.acq.done)
        else $error("stop command did not end acquisition");

    AST_NO_EARLY_SAMPLE: assert property (
        s_reg.acq.sample |-> $past(s_reg.st) == atc_pkg::ST_ACQ || $past(s_reg.st) == atc_pkg::ST_POST)
        else $error("sample taken outside the acquiring states");

    AST_REF_ARMED: assert property (
        s_reg.ref_pulse |-> $past(s_reg.pre_cnt) == $past(s_reg.cfg.pretrig) && $past(s_reg.cfg.ref_en))
        else $error("reference accepted before pretrigger count");

    AST_POST_BOUND: assert property (
        s_reg.st == atc_pkg::ST_POST |-> s_reg.post_cnt <= post_total)
        else $error("posttrigger count overran");

    AST_HOLD_SUSPENDS: assert property (
        held && s_reg.st == atc_pkg::ST_ACQ |=> !s_reg.acq.sample)
        else $error("sample issued while hold active");

    AST_ADDR_WRAP: assert property (
        s_reg.acq.active && s_reg.cfg.ref_en && s_reg.cfg.buf_size != '0
        |-> s_reg.acq.addr < s_reg.cfg.buf_size)
        else $error("buffer address left the circular range");

endmodule : atc_trigger_ctrl

// [atc_src_model.sv]
`timescale 1ns/1ps

module atc_src_model (
    // Bench control.
    input wire logic clk_i,
    input wire logic [3:0] fire_i,
    input wire logic go_i,
    input wire logic hold_i,
    // Source levels.
    output logic [15:0] src_o
);
    logic [15:0] hi_reg = 16'h0000;
    logic [2:0] len_reg = 3'h0;

    // A fired source stays high for a few cycles, so it gives one rising edge.
    always @(posedge clk_i) begin
        if (go_i) begin
            hi_reg <= 16'h0001 << fire_i;
            len_reg <= 3'h4;
        end else if (len_reg != 3'h0) begin
            len_reg <= len_reg - 3'h1;
        end else begin
            hi_reg <= 16'h0000;
        end
    end

    assign src_o = hi_reg | {12'h000, hold_i, 3'h0};
endmodule : atc_src_model

// [atc_trigger_ctrl_tb.sv]
`timescale 1ns/1ps

module atc_trigger_ctrl_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic go = 1'b0;
    logic hold = 1'b0;
    logic [3:0] fire = 4'h0;
    logic [31:0] rdata;
    logic [15:0] src;
    logic [15:0] baddr;
    logic [7:0] fl;
    logic smp;
    logic act;
    logic done;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int sc = 0;
    int p5 = 0;
    int p6 = 0;
    int post = 0;
    int maxa = 0;
    int b;
    int p;
    int i;

    always #12.5 clk = ~clk;

    atc_trigger_ctrl atc_trigger_ctrl_inst (.SYS_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .FUNC_LINE_I(src[7:0]), .CNT_OUT_I(src[9:8]),
        .INT_SIG_I(src[13:10]), .ANA_EVT_I(src[15:14]), .SAMPLE_O(smp), .BUF_ADDR_O(baddr),
        .ACTIVE_O(act), .DONE_O(done), .FUNC_LINE_O(fl));

    atc_src_model atc_src_model_inst (.clk_i(clk), .fire_i(fire), .go_i(go), .hold_i(hold), .src_o(src));

    always @(posedge clk) begin
        cyc <= cyc + 1;
        sc <= sc + (smp === 1'b1);
        p5 <= p5 + (fl[5] === 1'b1);
        p6 <= p6 + (fl[6] === 1'b1);
        post <= (fl[6] === 1'b1) ? 0 : post + (smp === 1'b1);
        if (smp === 1'b1 && baddr > maxa) begin
            maxa <= baddr;
        end
    end

    always @(posedge clk) begin
        if (cyc == 5000) begin
            err_count++;
            end_sim();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wr_reg

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
        check(d, exp);
        @(posedge clk);
    endtask : rchk

    task automatic fire_src(input logic [3:0] s);
        fire <= s;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
    endtask : fire_src

    task automatic wait_done();
        for (int k = 0; k < 500 && done !== 1'b1; k++) @(posedge clk);
        // One more edge, so the counters have taken the last sample.
        @(posedge clk);
        check(done, 1'b1);
    endtask : wait_done

    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rchk(8'h08, 32'h0000_0010);
        rchk(8'h40, 32'h0000_0000);
        wr_reg(8'h08, 32'h0000_0005);
        wr_reg(8'h10, 32'h0000_0002);
        b = sc;
        wr_reg(8'h18, 32'h0000_0001);
        wait_done();
        check(sc - b, 5);
        rchk(8'h20, 32'h0000_0005);
        wr_reg(8'h00, 32'h0000_0082);
        wr_reg(8'h04, 32'h0000_5008);
        wr_reg(8'h14, 32'h0000_0004);
        b = sc;
        p = p5;
        wr_reg(8'h18, 32'h0000_0001);
        repeat (30) @(posedge clk);
        check(sc - b, 0);
        fire_src(4'h8);
        for (i = 0; i < 20 && fl[5] !== 1'b1; i++) @(posedge clk);
        for (i = 0; i < 20 && smp !== 1'b1; i++) @(posedge clk);
        check(i, 6);
        wait_done();
        check(sc - b, 5);
        check(p5 - p, 1);
        wr_reg(8'h00, 32'h0000_0108);
        wr_reg(8'h04, 32'h0006_00E0);
        wr_reg(8'h08, 32'h0000_0006);
        wr_reg(8'h0C, 32'h0000_0002);
        wr_reg(8'h10, 32'h0000_0008);
        wr_reg(8'h14, 32'h0000_0000);
        p = p6;
        wr_reg(8'h18, 32'h0000_0001);
        fire_src(4'hE);
        repeat (40) @(posedge clk);
        check(p6 - p, 0);
        check(done, 1'b0);
        fire_src(4'hE);
        wait_done();
        check(p6 - p, 1);
        check(post, 4);
        check(maxa, 5);
        wr_reg(8'h00, 32'h0000_0027);
        wr_reg(8'h04, 32'h0000_0300);
        wr_reg(8'h10, 32'h0000_0002);
        wr_reg(8'h18, 32'h0000_0001);
        b = sc;
        fire_src(4'h0);
        repeat (6) @(posedge clk);
        check(sc - b, 0);
        repeat (12) @(posedge clk);
        hold <= 1'b1;
        repeat (6) @(posedge clk);
        b = sc;
        repeat (20) @(posedge clk);
        check(sc - b, 0);
        hold <= 1'b0;
        repeat (20) @(posedge clk);
        check(sc - b > 5, 1);
        wr_reg(8'h00, 32'h0000_0061);
        repeat (6) @(posedge clk);
        b = sc;
        repeat (20) @(posedge clk);
        check(sc - b, 0);
        check(act, 1'b1);
        wr_reg(8'h18, 32'h0000_0002);
        @(posedge clk);
        check({act, done}, 2'b01);
        end_sim();
    end
endmodule : atc_trigger_ctrl_tb
